// file: hdl/pin_mux_pkg.sv
package pin_mux_pkg;
  // Subaddresses of the registers held here
  localparam logic [7:0] ADDR_PIN_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h1E;
  localparam logic [7:0] ADDR_BLANK_SECOND = 8'h31;
  localparam logic [7:0] ADDR_BLANK_FIRST = 8'h32;
  localparam logic [7:0] ADDR_PORT = 8'h34;
  // Values after reset
  localparam logic [7:0] PIN_CFG_RESET = 8'h00;
  localparam logic [7:0] BLANK_FIRST_RESET = 8'h00;
  localparam logic [7:0] BLANK_SECOND_RESET = 8'h00;
  localparam logic [15:0] PORT_RESET = 16'h0000;
  // Writable bits; reserved bits read back as zero
  localparam logic [7:0] PIN_CFG_MASK = 8'hE7;
  localparam logic [7:0] BLANK_FIRST_MASK = 8'h9F;
  localparam logic [7:0] BLANK_SECOND_MASK = 8'h7F;
  // Output pin configuration fields
  localparam int STRENGTH_LSB = 0;
  localparam int RESISTOR_BIT = 5;
  localparam int CPIN_FN_LSB = 6;
  // First fast blank mode fields
  localparam int B1_FORCE_HIGH_BIT = 0;
  localparam int BLANK_POL_BIT = 1;
  localparam int CLAMP_REF_BIT = 2;
  localparam int FULL_LINE_BIT = 3;
  localparam int FLYBACK_POL_BIT = 4;
  localparam int B1_FORCE_LOW_BIT = 7;
  // Second fast blank mode fields
  localparam int B2_FORCE_HIGH_BIT = 0;
  localparam int B2_FORCE_LOW_BIT = 1;
  localparam int PRIORITY_BIT = 2;
  localparam int MONITOR_SEL_BIT = 3;
  localparam int HC_PIN_EN_BIT = 4;
  localparam int HC_FORCE_HIGH_BIT = 5;
  localparam int HC_POL_BIT = 6;
  // General port fields
  localparam int PORT_DATA_LSB = 0;
  localparam int FRONT_SYNC_BIT = 7;
  localparam int PORT_DIR_LSB = 8;
  localparam int PORT_SEL_BIT = 15;
  localparam int STATUS_BLANK_BIT = 3;
  // Horizontal drive clock on the composite pin
  localparam int CLK_PERIOD_NS = 4;
  localparam int HCLK_PERIOD_NS = 1000;
  localparam int HCLK_HALF_CYCLES = HCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] HCLK_HALF_LAST = 8'(HCLK_HALF_CYCLES - 1);
  // Functions of the composite sync pin
  typedef enum logic [1:0] {
    CPIN_SYNC, CPIN_FIELD, CPIN_ZERO, CPIN_HCLK
  } composite_fn_t;
endpackage

// file: hdl/blank_cond_if.sv
`timescale 1ns/10ps
interface blank_cond_if;
  logic pin;
  logic invert;
  logic force_high;
  logic force_low;
  logic level;
  modport cond (input pin, input invert, input force_high, input force_low, output level);
  modport ctrl (output pin, output invert, output force_high, output force_low, input level);
endinterface

// file: hdl/signal_condition.sv
`timescale 1ns/10ps
// Forcing, polarity and registering of one blank or contrast signal
module signal_condition (
  input wire logic clk_in,
  input wire logic rst_b_in,
  blank_cond_if.cond sig
);
  logic level_q;
  logic level_d;

  // Force high beats force low; otherwise the pin at its active level
  assign level_d = sig.force_high ? 1'b1 : (sig.force_low ? 1'b0 : (sig.pin ^ sig.invert));
  assign sig.level = level_q;

  // Output register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  property p_force_wins;
    @(posedge clk_in) disable iff (!rst_b_in)
    (sig.force_high && sig.force_low) |=> level_q;
  endproperty
  a_force_wins: assert property (p_force_wins) else $error("force high lost to force low");
endmodule // signal_condition

// file: hdl/port_pin_cell.sv
`timescale 1ns/10ps
// One general port pin with an alternate output function
module port_pin_cell (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic port_en_in,
  input wire logic dir_out_in,
  input wire logic data_in,
  input wire logic alt_sel_in,
  input wire logic alt_value_in,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_out,
  output logic read_out
);
  logic pad_q;
  logic oe_q;
  logic read_q;
  logic oe_d;
  logic pad_d;

  // Alternate function drives; else the port drives only as an output
  assign oe_d = alt_sel_in | (port_en_in & dir_out_in);
  assign pad_d = alt_sel_in ? alt_value_in : data_in;
  assign pad_out = pad_q;
  assign pad_oe_out = oe_q;
  assign read_out = read_q;

  // Pad drive and sampled pin level; a disabled port bit reads zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pad_q <= 1'b0;
      oe_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      oe_q <= oe_d;
      read_q <= pad_in & port_en_in;
    end
  end
endmodule // port_pin_cell

// file: hdl/video_pin_fastblank_general_port_control.sv
`timescale 1ns/10ps
// What this block does
// - Low three bits set sync pin strength
// - Bit five switches deflection output resistor
// - Composite pin: sync, field, zero, 1 MHz
// - Blank one forced high by bit zero
// - Blank one forced low by bit seven
// - Bit one sets blank active level
// - Bit two enables RGB clamp reference
// - Bit three selects full line window
// - Bit four sets flyback active level
// - Blank two forced high by bit zero
// - Blank two forced low by bit one
// - Bit two picks which blank input wins
// - Bit three picks monitored blank input
// - Bit four: port pin zero or contrast
// - Bit five forces half contrast high
// - Bit six sets half contrast pin level
// - Port data and per-pin direction bits
// - Bit seven puts front sync on pin one
// - Bit fifteen: colour outputs or port bits
// - Status bit shows monitored blank pin level
module video_pin_fastblank_general_port_control (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic main_sync_in,
  input wire logic composite_sync_in,
  input wire logic field_two_in,
  output logic [2:0] sync_pin_strength_out,
  output logic deflection_resistor_enable_out,
  output logic main_sync_pin_out,
  output logic composite_sync_pin_out,
  input wire logic blank_input_one_in,
  input wire logic blank_input_two_in,
  input wire logic flyback_in,
  output logic blank_one_out,
  output logic blank_two_out,
  output logic blank_active_out,
  output logic blank_source_two_out,
  output logic flyback_active_out,
  output logic rgb_clamp_reference_enable_out,
  output logic full_line_window_out,
  output logic half_contrast_out,
  input wire logic front_sync_in,
  input wire logic [4:0] colour_in,
  input wire logic [6:0] port_pin_in,
  output logic [6:0] port_pin_out,
  output logic [6:0] port_pin_oe_out
);
  logic [7:0] pin_cfg_q;
  logic [7:0] blank_first_q;
  logic [7:0] blank_second_q;
  logic [15:0] port_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [7:0] hclk_cnt_q;
  logic hclk_q;
  logic csync_q;
  logic msync_q;
  logic flyback_q;
  logic active_q;
  logic source_two_q;
  logic monitor_q;
  logic [6:0] port_read;

  // Register write decode
  wire wr_pin_cfg = reg_wr_in && (reg_addr_in == pin_mux_pkg::ADDR_PIN_CFG);
  wire wr_first = reg_wr_in && (reg_addr_in == pin_mux_pkg::ADDR_BLANK_FIRST);
  wire wr_second = reg_wr_in && (reg_addr_in == pin_mux_pkg::ADDR_BLANK_SECOND);
  wire wr_port = reg_wr_in && (reg_addr_in == pin_mux_pkg::ADDR_PORT);

  // Control bit fields
  wire b1_force_high = blank_first_q[pin_mux_pkg::B1_FORCE_HIGH_BIT];
  wire b1_force_low = blank_first_q[pin_mux_pkg::B1_FORCE_LOW_BIT];
  wire blank_pol = blank_first_q[pin_mux_pkg::BLANK_POL_BIT];
  wire flyback_pol = blank_first_q[pin_mux_pkg::FLYBACK_POL_BIT];
  wire b2_force_high = blank_second_q[pin_mux_pkg::B2_FORCE_HIGH_BIT];
  wire b2_force_low = blank_second_q[pin_mux_pkg::B2_FORCE_LOW_BIT];
  wire priority_two = blank_second_q[pin_mux_pkg::PRIORITY_BIT];
  wire monitor_two = blank_second_q[pin_mux_pkg::MONITOR_SEL_BIT];
  wire hc_pin_en = blank_second_q[pin_mux_pkg::HC_PIN_EN_BIT];
  wire hc_force_high = blank_second_q[pin_mux_pkg::HC_FORCE_HIGH_BIT];
  wire hc_pol = blank_second_q[pin_mux_pkg::HC_POL_BIT];
  wire [6:0] port_data = port_q[pin_mux_pkg::PORT_DATA_LSB +: 7];
  wire front_sync_en = port_q[pin_mux_pkg::FRONT_SYNC_BIT];
  wire [6:0] port_dir = port_q[pin_mux_pkg::PORT_DIR_LSB +: 7];
  wire port_sel = port_q[pin_mux_pkg::PORT_SEL_BIT];
  wire pin_mux_pkg::composite_fn_t cpin_fn =
    pin_mux_pkg::composite_fn_t'(pin_cfg_q[pin_mux_pkg::CPIN_FN_LSB +: 2]);

  // Configuration registers, reserved bits held at zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_cfg_q <= pin_mux_pkg::PIN_CFG_RESET;
    end else if (wr_pin_cfg) begin
      pin_cfg_q <= reg_wdata_in[7:0] & pin_mux_pkg::PIN_CFG_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blank_first_q <= pin_mux_pkg::BLANK_FIRST_RESET;
    end else if (wr_first) begin
      blank_first_q <= reg_wdata_in[7:0] & pin_mux_pkg::BLANK_FIRST_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blank_second_q <= pin_mux_pkg::BLANK_SECOND_RESET;
    end else if (wr_second) begin
      blank_second_q <= reg_wdata_in[7:0] & pin_mux_pkg::BLANK_SECOND_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_q <= pin_mux_pkg::PORT_RESET;
    end else if (wr_port) begin
      port_q <= reg_wdata_in;
    end
  end

  // Read decode; unmapped subaddresses read zero
  wire rd_pin_cfg = reg_addr_in == pin_mux_pkg::ADDR_PIN_CFG;
  wire rd_first = reg_addr_in == pin_mux_pkg::ADDR_BLANK_FIRST;
  wire rd_second = reg_addr_in == pin_mux_pkg::ADDR_BLANK_SECOND;
  wire rd_port = reg_addr_in == pin_mux_pkg::ADDR_PORT;
  wire rd_status = reg_addr_in == pin_mux_pkg::ADDR_STATUS;
  wire [15:0] status_word = 16'(monitor_q) << pin_mux_pkg::STATUS_BLANK_BIT;
  wire [15:0] port_word = {port_q[15:7], port_read};
  wire [15:0] rdata_d = rd_pin_cfg ? {8'h00, pin_cfg_q} :
                        rd_first ? {8'h00, blank_first_q} :
                        rd_second ? {8'h00, blank_second_q} :
                        rd_port ? port_word :
                        rd_status ? status_word : 16'h0000;

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // Sync pin strength and deflection resistor straight from the register
  assign sync_pin_strength_out = pin_cfg_q[pin_mux_pkg::STRENGTH_LSB +: 3];
  assign deflection_resistor_enable_out = pin_cfg_q[pin_mux_pkg::RESISTOR_BIT];

  // 1 MHz horizontal drive clock divided from the core clock
  wire hclk_wrap = hclk_cnt_q == pin_mux_pkg::HCLK_HALF_LAST;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hclk_cnt_q <= 8'h00;
      hclk_q <= 1'b0;
    end else begin
      hclk_cnt_q <= hclk_wrap ? 8'h00 : hclk_cnt_q + 8'h01;
      hclk_q <= hclk_q ^ hclk_wrap;
    end
  end

  // Composite pin function select
  logic csync_d;
  always_comb begin
    case (cpin_fn)
      pin_mux_pkg::CPIN_SYNC: csync_d = composite_sync_in;
      pin_mux_pkg::CPIN_FIELD: csync_d = field_two_in;
      pin_mux_pkg::CPIN_ZERO: csync_d = 1'b0;
      pin_mux_pkg::CPIN_HCLK: csync_d = hclk_q;
      default: csync_d = 1'b0;
    endcase
  end

  // Registered sync pins, flyback level and monitor sample
  wire monitor_pin = monitor_two ? blank_input_two_in : blank_input_one_in;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      csync_q <= 1'b0;
      msync_q <= 1'b0;
      flyback_q <= 1'b0;
      monitor_q <= 1'b0;
    end else begin
      csync_q <= csync_d;
      msync_q <= main_sync_in;
      flyback_q <= flyback_in ^ flyback_pol;
      monitor_q <= monitor_pin;
    end
  end

  assign composite_sync_pin_out = csync_q;
  assign main_sync_pin_out = msync_q;
  assign flyback_active_out = flyback_q;
  assign rgb_clamp_reference_enable_out = blank_first_q[pin_mux_pkg::CLAMP_REF_BIT];
  assign full_line_window_out = blank_first_q[pin_mux_pkg::FULL_LINE_BIT];

  // Fast blank one, fast blank two and half contrast conditioning
  blank_cond_if blank_one_c ();
  blank_cond_if blank_two_c ();
  blank_cond_if contrast_c ();

  assign blank_one_c.pin = blank_input_one_in;
  assign blank_one_c.invert = blank_pol;
  assign blank_one_c.force_high = b1_force_high;
  assign blank_one_c.force_low = b1_force_low;
  assign blank_two_c.pin = blank_input_two_in;
  assign blank_two_c.invert = blank_pol;
  assign blank_two_c.force_high = b2_force_high;
  assign blank_two_c.force_low = b2_force_low;
  assign contrast_c.pin = hc_pin_en & (port_pin_in[0] ^ hc_pol);
  assign contrast_c.invert = 1'b0;
  assign contrast_c.force_high = hc_force_high;
  assign contrast_c.force_low = 1'b0;

  signal_condition u_blank_one (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sig(blank_one_c)
  );

  signal_condition u_blank_two (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sig(blank_two_c)
  );

  signal_condition u_contrast (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sig(contrast_c)
  );

  assign blank_one_out = blank_one_c.level;
  assign blank_two_out = blank_two_c.level;
  assign half_contrast_out = contrast_c.level;

  // Priority between the two blank sources
  wire both_active = blank_one_c.level & blank_two_c.level;
  wire source_two_d = both_active ? priority_two : blank_two_c.level;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_q <= 1'b0;
      source_two_q <= 1'b0;
    end else begin
      active_q <= blank_one_c.level | blank_two_c.level;
      source_two_q <= source_two_d;
    end
  end

  assign blank_active_out = active_q;
  assign blank_source_two_out = source_two_q;

  // Port pin enables and alternate functions per pin
  wire [6:0] pin_port_en = {{5{port_sel}}, 1'b1, ~hc_pin_en};
  wire [6:0] pin_alt_sel = {{5{~port_sel}}, front_sync_en, 1'b0};
  wire [6:0] pin_alt_val = {colour_in, front_sync_in, 1'b0};

  for (genvar k = 0; k < 7; k++) begin : g_port
    port_pin_cell u_cell (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .port_en_in(pin_port_en[k]),
      .dir_out_in(port_dir[k]),
      .data_in(port_data[k]),
      .alt_sel_in(pin_alt_sel[k]),
      .alt_value_in(pin_alt_val[k]),
      .pad_in(port_pin_in[k]),
      .pad_out(port_pin_out[k]),
      .pad_oe_out(port_pin_oe_out[k]),
      .read_out(port_read[k])
    );
  end

  // Checks on the behaviour above
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_cfg_write;
    reg_wr_in && (reg_addr_in == pin_mux_pkg::ADDR_PIN_CFG);
  endsequence

  sequence s_status_read;
    reg_rd_in && (reg_addr_in == pin_mux_pkg::ADDR_STATUS);
  endsequence

  property p_strength;
    s_cfg_write |=> sync_pin_strength_out == $past(reg_wdata_in[2:0]);
  endproperty
  a_strength: assert property (p_strength) else $error("strength not taken");

  property p_resistor;
    s_cfg_write |=> deflection_resistor_enable_out == $past(reg_wdata_in[5]);
  endproperty
  a_resistor: assert property (p_resistor) else $error("resistor bit not taken");

  property p_cpin_zero;
    (cpin_fn == pin_mux_pkg::CPIN_ZERO) |=> !composite_sync_pin_out;
  endproperty
  a_cpin_zero: assert property (p_cpin_zero) else $error("no interlace pin not low");

  property p_cpin_hclk;
    (cpin_fn == pin_mux_pkg::CPIN_HCLK) && $rose(hclk_q) |-> ##125 $fell(hclk_q);
  endproperty
  a_cpin_hclk: assert property (p_cpin_hclk) else $error("drive clock half period wrong");

  property p_b1_high;
    b1_force_high |=> blank_one_out;
  endproperty
  a_b1_high: assert property (p_b1_high) else $error("blank one not forced high");

  property p_b1_low;
    b1_force_low && !b1_force_high |=> !blank_one_out;
  endproperty
  a_b1_low: assert property (p_b1_low) else $error("blank one not forced low");

  property p_b1_follow;
    !b1_force_high && !b1_force_low |=> blank_one_out == $past(blank_input_one_in ^ blank_pol);
  endproperty
  a_b1_follow: assert property (p_b1_follow) else $error("blank one not following pin");

  property p_b2_force;
    b2_force_high ##1 b2_force_high |-> blank_two_out ##1 blank_two_out;
  endproperty
  a_b2_force: assert property (p_b2_force) else $error("blank two not forced high");

  property p_priority;
    blank_one_out && blank_two_out |=> blank_source_two_out == $past(priority_two);
  endproperty
  a_priority: assert property (p_priority) else $error("blank priority wrong");

  property p_hc_off;
    !hc_pin_en && !hc_force_high |=> !half_contrast_out;
  endproperty
  a_hc_off: assert property (p_hc_off) else $error("half contrast active while disabled");

  property p_front_sync;
    front_sync_en |=> port_pin_oe_out[1] && port_pin_out[1] == $past(front_sync_in);
  endproperty
  a_front_sync: assert property (p_front_sync) else $error("front sync not on pin one");

  property p_colour;
    rst_b_in && !port_sel |=> port_pin_oe_out[6:2] == 5'h1F && port_pin_out[6:2] == $past(colour_in);
  endproperty
  a_colour: assert property (p_colour) else $error("colour outputs not driven");

  property p_status;
    s_status_read |=> reg_rvalid_out && reg_rdata_out[3] == $past(monitor_q);
  endproperty
  a_status: assert property (p_status) else $error("status blank level wrong");
endmodule // video_pin_fastblank_general_port_control

// file: testbench/far_side_model.sv
`timescale 1ns/10ps
// Sources on the far side of the pins: overlay blanking, flyback and port devices
module far_side_model (
  input wire logic blank_one_level_in,
  input wire logic blank_two_level_in,
  input wire logic flyback_level_in,
  input wire logic [6:0] port_drive_in,
  input wire logic [6:0] pad_out_in,
  input wire logic [6:0] pad_oe_in,
  output logic blank_input_one_out,
  output logic blank_input_two_out,
  output logic flyback_out,
  output logic [6:0] port_level_out
);
  // Blank and flyback pins are plain driven inputs of the device
  assign blank_input_one_out = blank_one_level_in;
  assign blank_input_two_out = blank_two_level_in;
  assign flyback_out = flyback_level_in;
  // Pad level: device wins where it drives, the outside device elsewhere
  assign port_level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & port_drive_in);
endmodule // far_side_model

// file: testbench/video_pin_fastblank_general_port_control_bench.sv
`timescale 1ns/10ps
// Drives the pin block through its register port and pins and judges the results
module video_pin_fastblank_general_port_control_bench;
  logic clk_in, rst_b_in, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic main_sync, comp_sync, field_two, front_sync, lvl_one, lvl_two, lvl_fly;
  logic [2:0] strength;
  logic resistor, main_pin, comp_pin, blank_one, blank_two, blank_active, source_two;
  logic fly_active, clamp_en, full_line, half_contrast, pin_one, pin_two, fly_pin;
  logic [4:0] colour;
  logic [6:0] ext_port, port_level, port_out, port_oe;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;

  video_pin_fastblank_general_port_control u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .reg_rvalid_out(reg_rvalid), .main_sync_in(main_sync), .composite_sync_in(comp_sync),
    .field_two_in(field_two), .sync_pin_strength_out(strength),
    .deflection_resistor_enable_out(resistor), .main_sync_pin_out(main_pin),
    .composite_sync_pin_out(comp_pin), .blank_input_one_in(pin_one),
    .blank_input_two_in(pin_two), .flyback_in(fly_pin), .blank_one_out(blank_one),
    .blank_two_out(blank_two), .blank_active_out(blank_active),
    .blank_source_two_out(source_two), .flyback_active_out(fly_active),
    .rgb_clamp_reference_enable_out(clamp_en), .full_line_window_out(full_line),
    .half_contrast_out(half_contrast), .front_sync_in(front_sync), .colour_in(colour),
    .port_pin_in(port_level), .port_pin_out(port_out), .port_pin_oe_out(port_oe)
  );

  far_side_model u_far (
    .blank_one_level_in(lvl_one), .blank_two_level_in(lvl_two), .flyback_level_in(lvl_fly),
    .port_drive_in(ext_port), .pad_out_in(port_out), .pad_oe_in(port_oe),
    .blank_input_one_out(pin_one), .blank_input_two_out(pin_two), .flyback_out(fly_pin),
    .port_level_out(port_level)
  );

  // Clock at 250 MHz
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Lets registered outputs follow a change
  task automatic settle();
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string msg);
    logic [15:0] got;
    got = 'x;
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in);
      if (reg_rvalid === 1'b1) begin
        got = reg_rdata;
        break;
      end
    end
    check(got, exp, msg);
  endtask

  task automatic test_reset();
    settle();
    check(16'(port_oe), 16'h007C, "colour pins driven");
    check(16'(port_out[6:2]), 16'(colour), "colour on pins");
    rd_chk(8'h10, 16'h0000, "pin cfg reset");
    rd_chk(8'h31, 16'h0000, "blank two reset");
    rd_chk(8'h32, 16'h0000, "blank one reset");
    rd_chk(8'h34, 16'h0000, "port reset");
    rd_chk(8'h55, 16'h0000, "unmapped read");
  endtask

  task automatic test_sync_pins();
    int highs;
    logic e;
    wr(8'h10, 16'hFFFF);
    rd_chk(8'h10, 16'h00E7, "pin cfg readback");
    settle();
    check(16'(strength), 16'h0007, "strength");
    check(16'(resistor), 16'h0001, "resistor");
    highs = 0;
    for (int i = 0; i < 250; i++) begin
      @(negedge clk_in);
      highs += (comp_pin === 1'b1) ? 1 : 0;
    end
    check(16'(highs), 16'h007D, "drive clock duty");
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        wr(8'h10, {8'h00, 2'(m), 6'h02});
        @(posedge clk_in);
        comp_sync <= s[0];
        field_two <= ~s[0];
        main_sync <= s[0];
        settle();
        e = (m == 0) ? s[0] : (m == 1) ? ~s[0] : 1'b0;
        check(16'(comp_pin), 16'(e), "composite pin");
        check(16'(main_pin), 16'(s[0]), "main sync pin");
        check(16'({strength, resistor}), 16'h0004, "strength kept");
      end
    end
  endtask

  task automatic test_blank_one();
    logic [7:0] cfg [6] = '{8'h00, 8'h02, 8'h01, 8'h80, 8'h81, 8'h83};
    logic [7:0] misc [2] = '{8'h00, 8'h1C};
    logic e;
    foreach (cfg[i]) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h32, {8'h00, cfg[i]});
        @(posedge clk_in);
        lvl_one <= p[0];
        settle();
        e = cfg[i][0] ? 1'b1 : cfg[i][7] ? 1'b0 : (p[0] ^ cfg[i][1]);
        check(16'(blank_one), 16'(e), "blank one");
      end
    end
    foreach (misc[i]) begin
      wr(8'h32, {8'h00, misc[i]});
      @(posedge clk_in);
      lvl_fly <= 1'b1;
      settle();
      check(16'(fly_active), 16'(!misc[i][4]), "flyback");
      check(16'(clamp_en), 16'(misc[i][2]), "clamp ref");
      check(16'(full_line), 16'(misc[i][3]), "full line");
    end
  endtask

  task automatic test_blank_two();
    logic e;
    wr(8'h32, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h31, 16'(c));
        @(posedge clk_in);
        lvl_two <= p[0];
        settle();
        e = (c == 1 || c == 3) ? 1'b1 : (c == 2) ? 1'b0 : p[0];
        check(16'(blank_two), 16'(e), "blank two");
      end
    end
    for (int pr = 0; pr < 2; pr++) begin
      wr(8'h31, 16'(pr * 4));
      @(posedge clk_in);
      lvl_one <= 1'b1;
      lvl_two <= 1'b1;
      settle();
      check(16'({blank_active, source_two}), 16'(2 + pr), "both active");
    end
    @(posedge clk_in);
    lvl_two <= 1'b0;
    settle();
    check(16'({blank_active, source_two}), 16'h0002, "one only");
    rd_chk(8'h1E, 16'h0008, "monitor first pin");
    wr(8'h31, 16'h0008);
    rd_chk(8'h1E, 16'h0000, "monitor second pin");
  endtask

  task automatic test_contrast();
    logic [7:0] cfg [6] = '{8'h00, 8'h10, 8'h50, 8'h20, 8'h60, 8'h30};
    logic e;
    foreach (cfg[i]) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h31, {8'h00, cfg[i]});
        @(posedge clk_in);
        ext_port <= {6'h00, p[0]};
        settle();
        e = cfg[i][5] ? 1'b1 : cfg[i][4] ? (p[0] ^ cfg[i][6]) : 1'b0;
        check(16'(half_contrast), 16'(e), "half contrast");
      end
    end
  endtask

  task automatic test_port();
    wr(8'h31, 16'h0000);
    wr(8'h34, 16'hFF55);
    settle();
    check(16'({port_oe, port_out}), 16'h3FD5, "port outputs");
    wr(8'h31, 16'h0010);
    settle();
    check(16'(port_oe), 16'h007E, "pin zero taken");
    wr(8'h31, 16'h0000);
    wr(8'h34, 16'h8080);
    for (int f = 0; f < 2; f++) begin
      @(posedge clk_in);
      front_sync <= f[0];
      settle();
      check(16'({port_oe, port_out[1]}), 16'(4 + f), "front sync");
    end
    wr(8'h34, 16'h8000);
    @(posedge clk_in);
    ext_port <= 7'h5B;
    rd_chk(8'h34, 16'h805B, "port inputs");
    wr(8'h31, 16'h0010);
    rd_chk(8'h34, 16'h805A, "pin zero not port");
    wr(8'h34, 16'h0000);
    rd_chk(8'h34, 16'h0002, "colour pins not port");
  endtask

  // Main sequence
  initial begin
    rst_b_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    {reg_wr, reg_rd, main_sync, comp_sync, field_two, front_sync} = 6'h00;
    {lvl_one, lvl_two, lvl_fly} = 3'h0;
    ext_port = 7'h00;
    colour = 5'h15;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    test_reset();
    test_sync_pins();
    test_blank_one();
    test_blank_two();
    test_contrast();
    test_port();
    finish_test();
  end
endmodule // video_pin_fastblank_general_port_control_bench
